// File: hdl/ssrvo_pkg.sv
package ssrvo_pkg;
  // clock and processor-cycle timing
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CPU_CYCLE_HZ  = 2_000_000;   // 2MHz bus cycle
  localparam int unsigned HALF_CYC      = CLK_HZ / (2 * CPU_CYCLE_HZ);
  localparam int unsigned ENV_SLOT_NS   = 2000;        // hold time per envelope slot
  localparam int unsigned ENV_SLOT_CYC  = (ENV_SLOT_NS * (CLK_HZ / 1_000_000)) / 1000;
  // master address map
  localparam logic [15:0] WIN_BASE      = 16'h6000;    // slave RAM window
  localparam logic [15:0] WIN_LAST      = 16'h67FF;
  localparam logic [1:0]  LOW_BANK_TOP  = 2'h0;        // lowest 16 k
  // field positions
  localparam int unsigned SNUM_LSB      = 2;           // slave number on data bits 4..2
  localparam int unsigned BANK_SEL_LSB  = 4;           // bank latch upper outputs
  localparam int unsigned BANK_ADR_LSB  = 0;           // banked upper address bits
  // sizes
  localparam int unsigned NSLAVE        = 8;
  localparam int unsigned NVOICE        = 4;
  localparam int unsigned NCOMP         = 8;
  localparam int unsigned NTIMER        = 5;
  localparam int unsigned NCHAN         = 5;
  localparam int unsigned RAM_AW        = 13;
  // reset values
  localparam logic [2:0]  SNUM_RST      = 3'h0;
  localparam logic [7:0]  BANK_RST      = 8'h00;
  localparam logic [15:0] TIMER_RST     = 16'hFFFF;
  localparam logic [2:0]  ROUTE_RST     = 3'h0;        // bright channel
endpackage

// File: hdl/ssrvo_top.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1: master latches slave number from data bits 4..2
// R2: window access decodes one of eight selects
// R3: external data driver only for off-board accesses
// R4: program select picks rom upper address source
// R5: bank latch banks lowest 16 k
// R6: master supplies timer clock to slaves
// R7: master loads parameters on every key press
// R8: bus switch passes owner bus, enables its driver
// R9: both buses 2MHz, slave phases inverted
// R10: ownership alternates every half cycle
// R11: slave cpu runs only after loading done
// R12: four pitch timers, one envelope timer
// R13: sequencer streams samples with no cpu
// R14: dacs accept samples only under transfer permit
// R15: timer ticks pace dac read-out
// R16: one envelope dac multiplexed over eight holds
// R17: crosspoint routes each output to one channel
// R18: up to eight slave boards
// R19: cpu only computes envelopes
// R20: host e phase grants master, else slave
module ssrvo_top
  import ssrvo_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  nrst_i,
  input  wire logic [15:0]           host_addr_i,
  input  wire logic [7:0]            host_data_i,
  input  wire logic                  host_valid_i,
  input  wire logic                  host_wr_i,
  input  wire logic                  slave_number_strobe_i,
  input  wire logic                  bank_strobe_i,
  input  wire logic                  local_sel_i,
  input  wire logic                  program_sel_i,
  input  wire logic [2:0]            board_id_i,
  input  wire logic                  load_done_i,
  input  wire logic [RAM_AW-1:0]     local_addr_i,
  input  wire logic                  local_valid_i,
  input  wire logic                  local_wr_i,
  input  wire logic                  slave_timer_clock_i,
  input  wire logic                  timer_wr_i,
  input  wire logic [2:0]            timer_idx_i,
  input  wire logic [15:0]           timer_data_i,
  input  wire logic                  dma_ack_i,
  input  wire logic [15:0]           dma_data_i,
  input  wire logic                  dac_transfer_permit_i,
  input  wire logic                  env_wr_i,
  input  wire logic [2:0]            env_idx_i,
  input  wire logic [11:0]           env_data_i,
  input  wire logic                  route_wr_i,
  input  wire logic [2:0]            route_idx_i,
  input  wire logic [2:0]            route_chan_i,
  output logic [NSLAVE-1:0]          slave_select_outputs_o,
  output logic                       ext_drv_en_o,
  output logic [3:0]                 system_rom_upper_address_o,
  output logic [3:0]                 banked_upper_address_o,
  output logic [7:0]                 bank_select_o,
  output logic                       host_e_phase_o,
  output logic                       host_q_phase_o,
  output logic                       local_e_phase_o,
  output logic                       local_q_phase_o,
  output logic [RAM_AW-1:0]          ram_addr_o,
  output logic                       ram_ce_o,
  output logic                       ram_we_o,
  output logic                       host_drv_en_o,
  output logic                       local_drv_en_o,
  output logic                       slave_run_o,
  output logic                       env_tick_o,
  output logic [NVOICE-1:0]          dma_req_o,
  output logic [NCOMP*8-1:0]         dac_sample_o,
  output logic [11:0]                env_dac_o,
  output logic [2:0]                 env_mux_sel_o,
  output logic                       env_hold_o,
  output logic [NCOMP*NCHAN-1:0]     channel_enable_o
);

  typedef enum logic [1:0] {SEQ_IDLE = 2'b01, SEQ_WAIT = 2'b10} ssrvo_seq_t;

  logic [2:0]  snum;           // latched slave number
  logic [7:0]  bank;           // bank latch
  logic        in_win;         // master inside slave ram window
  logic        own_host;       // ram owned by master bus
  logic [4:0]  half_cnt;       // half-cycle divider
  logic        host_hit;       // master selected this board

  // slave number latch, written by the master only
  always_ff @(posedge clock_i) begin
    if (!nrst_i) snum <= SNUM_RST;
    else if (slave_number_strobe_i) snum <= host_data_i[SNUM_LSB +: 3]; // R1
  end

  // window decode; three bits cover all eight boards
  assign in_win = host_valid_i && host_addr_i >= WIN_BASE && host_addr_i <= WIN_LAST;
  always_comb begin
    slave_select_outputs_o = '0;
    if (in_win) slave_select_outputs_o[snum] = 1'b1; // R2 R18
  end
  assign host_hit = slave_select_outputs_o[board_id_i];

  // driver only for off-board cycles; local ram, rom and timers keep it off
  assign ext_drv_en_o = host_valid_i && !local_sel_i; // R3

  // bank latch and banking of the low 16 k
  always_ff @(posedge clock_i) begin
    if (!nrst_i) bank <= BANK_RST;
    else if (bank_strobe_i) bank <= host_data_i; // R5
  end
  assign banked_upper_address_o = bank[BANK_ADR_LSB +: 4];
  always_comb begin
    bank_select_o = '0;
    if (host_valid_i && host_addr_i[15:14] == LOW_BANK_TOP)
      bank_select_o[bank[BANK_SEL_LSB +: 3]] = 1'b1; // R5
  end
  // program select chooses banked bits or plain address 15..14
  assign system_rom_upper_address_o = program_sel_i ? banked_upper_address_o
                                                    : {2'b00, host_addr_i[15:14]}; // R4

  // half-cycle divider: e toggles each half, q leads it by a quarter
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      half_cnt       <= '0;
      host_e_phase_o <= 1'b0;
      host_q_phase_o <= 1'b0;
    end else begin
      if (half_cnt == 5'(HALF_CYC - 1)) begin
        half_cnt       <= '0;
        host_e_phase_o <= ~host_e_phase_o; // R9 R10
      end else begin
        half_cnt <= half_cnt + 5'h01;
      end
      if (half_cnt == 5'(HALF_CYC / 2 - 1)) host_q_phase_o <= ~host_q_phase_o;
    end
  end
  // slave runs on the inverted master phases, half a cycle off
  assign local_e_phase_o = ~host_e_phase_o; // R9
  assign local_q_phase_o = ~host_q_phase_o; // R9
  assign own_host        = host_e_phase_o;  // R20

  // bus switch: owner's address and control registered onto the ram
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      ram_addr_o     <= '0;
      ram_ce_o       <= 1'b0;
      ram_we_o       <= 1'b0;
      host_drv_en_o  <= 1'b0;
      local_drv_en_o <= 1'b0;
    end else if (own_host) begin
      ram_addr_o     <= host_addr_i[RAM_AW-1:0]; // R8
      ram_ce_o       <= host_hit;
      ram_we_o       <= host_hit && host_wr_i;
      host_drv_en_o  <= host_hit;  // R8
      local_drv_en_o <= 1'b0;
    end else begin
      ram_addr_o     <= local_addr_i; // R8
      ram_ce_o       <= local_valid_i;
      ram_we_o       <= local_valid_i && local_wr_i;
      host_drv_en_o  <= 1'b0;
      local_drv_en_o <= local_valid_i; // R8
    end
  end

  // slave cpu held until the master reports its load finished
  always_ff @(posedge clock_i) begin
    if (!nrst_i) slave_run_o <= 1'b0;
    else if (load_done_i) slave_run_o <= 1'b1; // R11
  end

  // timer clock from the master board: three stages, second and third agree
  logic [2:0] tclk_s;
  logic       tclk_lvl;
  logic       tclk_rise;
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      tclk_s   <= '0;
      tclk_lvl <= 1'b0;
    end else begin
      tclk_s <= {tclk_s[1:0], slave_timer_clock_i};
      if (tclk_s[2] == tclk_s[1]) tclk_lvl <= tclk_s[2];
    end
  end
  assign tclk_rise = tclk_s[2] && tclk_s[1] && !tclk_lvl;

  // five reload timers; 0..3 pitch per voice, 4 envelope rate
  logic [NTIMER-1:0] tick;
  genvar g;
  generate
    for (g = 0; g < NTIMER; g++) begin : g_tmr
      logic [15:0] reload;   // period written by slave cpu
      logic [15:0] cnt;      // down counter on timer clock
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          reload <= TIMER_RST;
          cnt    <= TIMER_RST;
          tick[g] <= 1'b0;
        end else begin
          tick[g] <= 1'b0;
          // a write restarts the count, so a new period needs no full wrap first
          if (timer_wr_i && timer_idx_i == 3'(g)) begin
            reload <= timer_data_i; // R12
            cnt    <= timer_data_i;
          end else if (tclk_rise) begin
            if (cnt == 16'h0000) begin
              cnt     <= reload;
              tick[g] <= 1'b1; // R12
            end else begin
              cnt <= cnt - 16'h0001;
            end
          end
        end
      end
    end
  endgenerate
  assign env_tick_o = tick[NTIMER-1]; // R12 R19

  // sequencer: a pitch tick requests one word; dma ack lands two samples
  ssrvo_seq_t       seq, next_seq;
  logic [NVOICE-1:0] pend;          // voices awaiting a fetch
  logic [1:0]        cur;           // voice being served
  logic [7:0]        stage [NCOMP]; // fetched, not yet played
  always_ff @(posedge clock_i) begin
    if (!nrst_i) pend <= '0;
    // a tick in the ack cycle survives: set beats clear
    else pend <= (pend & ~((seq == SEQ_WAIT && dma_ack_i) ? (4'h1 << cur) : 4'h0))
                 | tick[NVOICE-1:0]; // R13 R15
  end
  always_comb begin
    next_seq = seq;
    case (seq)
      SEQ_IDLE: if (pend != '0) next_seq = SEQ_WAIT;
      SEQ_WAIT: if (dma_ack_i) next_seq = SEQ_IDLE;
      default:  next_seq = SEQ_IDLE;
    endcase
  end
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      seq <= SEQ_IDLE;
      cur <= '0;
    end else begin
      seq <= next_seq; // R13
      if (seq == SEQ_IDLE) begin
        // lowest pending voice first
        for (int v = NVOICE - 1; v >= 0; v--) if (pend[v]) cur <= 2'(v);
      end
    end
  end
  assign dma_req_o = (seq == SEQ_WAIT) ? (4'h1 << cur) : 4'h0; // R13

  // staging and paced dac load, one block per component
  generate
    for (g = 0; g < NCOMP; g++) begin : g_dac
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          stage[g] <= '0;
          dac_sample_o[g*8 +: 8] <= '0;
        end else begin
          if (seq == SEQ_WAIT && dma_ack_i && cur == 2'(g / 2))
            stage[g] <= dma_data_i[(g % 2)*8 +: 8]; // R13
          // pitch tick paces read-out, permit gates acceptance
          if (tick[g / 2] && dac_transfer_permit_i)
            dac_sample_o[g*8 +: 8] <= stage[g]; // R14 R15
        end
      end
    end
  endgenerate

  // envelope values from the slave cpu, scanned onto one dac
  logic [11:0] env [NCOMP];  // per-component envelope
  logic [7:0]  slot_cnt;     // cycles within a slot
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      for (int k = 0; k < NCOMP; k++) env[k] <= '0;
    end else if (env_wr_i) begin
      env[env_idx_i] <= env_data_i; // R19
    end
  end
  // hold strobe only in the second half of a slot, after the dac settles
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      slot_cnt      <= '0;
      env_mux_sel_o <= '0;
      env_dac_o     <= '0;
      env_hold_o    <= 1'b0;
    end else begin
      env_dac_o  <= env[env_mux_sel_o]; // R16
      env_hold_o <= slot_cnt >= 8'(ENV_SLOT_CYC / 2);
      if (slot_cnt == 8'(ENV_SLOT_CYC - 1)) begin
        slot_cnt      <= '0;
        env_mux_sel_o <= env_mux_sel_o + 3'h1; // R16
      end else begin
        slot_cnt <= slot_cnt + 8'h01;
      end
    end
  end

  // crosspoint: one channel per component output
  logic [2:0] route [NCOMP];
  generate
    for (g = 0; g < NCOMP; g++) begin : g_xp
      always_ff @(posedge clock_i) begin
        if (!nrst_i) route[g] <= ROUTE_RST;
        else if (route_wr_i && route_idx_i == 3'(g) && route_chan_i < 3'(NCHAN))
          route[g] <= route_chan_i; // R17
      end
      assign channel_enable_o[g*NCHAN +: NCHAN] = 5'h01 << route[g]; // R17
    end
  endgenerate

  // length of the present e level, counted for the half-cycle check
  logic       e_prev;   // e phase one clock ago
  logic [4:0] e_run;    // clocks the present level has stood
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      e_prev <= 1'b0;
      e_run  <= '0;
    end else begin
      e_prev <= host_e_phase_o;
      if (host_e_phase_o != e_prev) e_run <= 5'h01;
      else if (e_run != 5'h1F) e_run <= e_run + 5'h01;
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  AST_ONE_SELECT: assert property (in_win |-> $onehot(slave_select_outputs_o)) // R2
    else $error("window access without exactly one select");
  AST_NO_SELECT: assert property (!in_win |-> slave_select_outputs_o == '0) // R2
    else $error("select active outside window");
  AST_LATCH: assert property (slave_number_strobe_i ##1 in_win
      |-> slave_select_outputs_o[$past(host_data_i[4:2])]) // R1
    else $error("latched slave number not decoded");
  AST_EXT_OFF: assert property (local_sel_i |-> !ext_drv_en_o) // R3
    else $error("external driver on for local access");
  AST_ROM_SRC: assert property (program_sel_i |-> system_rom_upper_address_o == bank[3:0]) // R4
    else $error("rom upper address not banked");
  AST_HALF: assert property (host_e_phase_o != e_prev |-> e_run == 5'(HALF_CYC)) // R10
    else $error("ownership half cycle of wrong length");
  AST_EXCL: assert property (!(host_drv_en_o && local_drv_en_o)) // R8
    else $error("both data drivers enabled");
  AST_RUN: assert property (!$past(slave_run_o) && !$past(load_done_i) |-> !slave_run_o) // R11
    else $error("slave started before load done");
  AST_PERMIT: assert property (!dac_transfer_permit_i |=> $stable(dac_sample_o)) // R14
    else $error("dac changed without permit");
  AST_SERVE: assert property (seq == SEQ_IDLE && pend != '0 |=> seq == SEQ_WAIT ##[0:300] 1) // R13
    else $error("pending voice not served");

  COV_SELECT: cover property (slave_number_strobe_i ##[1:10] in_win);
  COV_FETCH: cover property (seq == SEQ_WAIT && dma_ack_i ##[1:50] tick[0]);
  COV_SCAN: cover property (env_mux_sel_o == 3'h7 ##1 env_mux_sel_o == 3'h7 [*2]);

endmodule
`default_nettype wire

// File: bench/ssrvo_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// master side: host bus cycles, strobes and the slave timer clock
module ssrvo_host_model (
  input  wire logic        clock_i,
  output logic [15:0]      host_addr_o,
  output logic [7:0]       host_data_o,
  output logic             host_valid_o,
  output logic             host_wr_o,
  output logic             slave_number_strobe_o,
  output logic             bank_strobe_o,
  output logic             local_sel_o,
  output logic             load_done_o,
  output logic             slave_timer_clock_o
);
  // idle bus at time zero
  initial begin
    {host_addr_o, host_data_o} = '0;
    {host_valid_o, host_wr_o, local_sel_o} = '0;
    {slave_number_strobe_o, bank_strobe_o, load_done_o} = '0;
    slave_timer_clock_o = 1'b0;
  end
  // free-running timer clock, never tied to the cycle phase
  always #62.5 slave_timer_clock_o = ~slave_timer_clock_o;
  // one master cycle, held until rel; 2MHz pacing left to the bench
  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w, input logic l);
    @(negedge clock_i);
    host_addr_o  = a;
    host_data_o  = d;
    host_wr_o    = w;
    local_sel_o  = l;
    host_valid_o = 1'b1;
  endtask
  // released lines show the inverse, so stale data cannot pass
  task automatic rel();
    @(negedge clock_i);
    host_valid_o = 1'b0;
    host_addr_o  = ~host_addr_o;
    host_data_o  = ~host_data_o;
  endtask
  // one-clock strobe; slave number rides on data bits 4..2
  task automatic strobe(input logic bank, input logic [7:0] d);
    @(negedge clock_i);
    host_data_o = d;
    if (bank) begin
      bank_strobe_o = 1'b1;
    end else begin
      slave_number_strobe_o = 1'b1;
    end
    @(negedge clock_i);
    {bank_strobe_o, slave_number_strobe_o} = '0;
    host_data_o = ~d;
  endtask
  // pulse once the parameter ram is loaded
  task automatic loaded();
    @(negedge clock_i);
    load_done_o = 1'b1;
    @(negedge clock_i);
    load_done_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bench/ssrvo_top_test.sv
`timescale 1ns/10ps
`default_nettype none
// bench for the slave board top; host side comes from the master model
module ssrvo_top_test;
  import ssrvo_pkg::*;
  logic clock_i, nrst_i, program_sel_i, local_valid_i, local_wr_i, timer_wr_i;
  logic dma_ack_i, dac_transfer_permit_i, env_wr_i, route_wr_i;
  logic [2:0] board_id_i, timer_idx_i, env_idx_i, route_idx_i, route_chan_i;
  logic [RAM_AW-1:0] local_addr_i, ram_addr_o;
  logic [15:0] timer_data_i, dma_data_i;
  logic [11:0] env_data_i, env_dac_o;
  wire logic [15:0] host_addr_i;
  wire logic [7:0] host_data_i;
  wire logic host_valid_i, host_wr_i, slave_number_strobe_i, bank_strobe_i;
  wire logic local_sel_i, load_done_i, slave_timer_clock_i;
  logic [7:0] slave_select_outputs_o, bank_select_o;
  logic ext_drv_en_o, host_e_phase_o, host_q_phase_o, local_e_phase_o, local_q_phase_o;
  logic ram_ce_o, ram_we_o, host_drv_en_o, local_drv_en_o, slave_run_o, env_tick_o, env_hold_o;
  logic [3:0] system_rom_upper_address_o, banked_upper_address_o, dma_req_o;
  logic [63:0] dac_sample_o;
  logic [2:0] env_mux_sel_o;
  logic [39:0] channel_enable_o;
  int n_errors, checks_done, i, k;
  ssrvo_top ssrvo_top_inst (
    .clock_i, .nrst_i, .host_addr_i, .host_data_i, .host_valid_i, .host_wr_i,
    .slave_number_strobe_i, .bank_strobe_i, .local_sel_i, .program_sel_i, .board_id_i,
    .load_done_i, .local_addr_i, .local_valid_i, .local_wr_i, .slave_timer_clock_i,
    .timer_wr_i, .timer_idx_i, .timer_data_i, .dma_ack_i, .dma_data_i,
    .dac_transfer_permit_i, .env_wr_i, .env_idx_i, .env_data_i, .route_wr_i,
    .route_idx_i, .route_chan_i, .slave_select_outputs_o, .ext_drv_en_o,
    .system_rom_upper_address_o, .banked_upper_address_o, .bank_select_o,
    .host_e_phase_o, .host_q_phase_o, .local_e_phase_o, .local_q_phase_o, .ram_addr_o,
    .ram_ce_o, .ram_we_o, .host_drv_en_o, .local_drv_en_o, .slave_run_o, .env_tick_o,
    .dma_req_o, .dac_sample_o, .env_dac_o, .env_mux_sel_o, .env_hold_o, .channel_enable_o
  );
  ssrvo_host_model ssrvo_host_model_inst (
    .clock_i, .host_addr_o(host_addr_i), .host_data_o(host_data_i),
    .host_valid_o(host_valid_i), .host_wr_o(host_wr_i),
    .slave_number_strobe_o(slave_number_strobe_i), .bank_strobe_o(bank_strobe_i),
    .local_sel_o(local_sel_i), .load_done_o(load_done_i),
    .slave_timer_clock_o(slave_timer_clock_i)
  );
  // 50 MHz system clock
  always #10 clock_i = ~clock_i;
  // compare and count; x never matches
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %0h want %0h", $time, got, exp);
    end
  endtask
  // verdict and stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // a wait that ran out counts and ends the run
  task automatic give_up();
    n_errors++;
    $display("BAD t=%0t wait ran out", $time);
    end_sim();
  endtask
  task automatic nclk(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // bounded wait for a host e phase level
  task automatic e_wait(input logic v);
    for (i = 0; i < 40 && host_e_phase_o !== v; i++) nclk(1);
    if (host_e_phase_o !== v) give_up();
  endtask
  task automatic t_reset();
    check(slave_select_outputs_o, 8'h00);
    check(slave_run_o, 1'b0);
    check(channel_enable_o, 40'h0842108421);
    check(dac_sample_o, 64'h0);
    $display("reset values done");
  endtask
  // every slave number decodes to its own select, window edges too
  task automatic t_select();
    for (int n = 0; n < NSLAVE; n++) begin
      ssrvo_host_model_inst.strobe(1'b0, {3'h0, n[2:0], 2'h0});
      ssrvo_host_model_inst.cyc(16'h6000 + 16'(n), 8'h00, 1'b0, 1'b0);
      #1 check(slave_select_outputs_o, 8'h01 << n);
      check(ext_drv_en_o, 1'b1);
    end
    ssrvo_host_model_inst.cyc(16'h67FF, 8'h00, 1'b0, 1'b0);
    #1 check(slave_select_outputs_o, 8'h80);
    ssrvo_host_model_inst.cyc(16'h6800, 8'h00, 1'b0, 1'b0);
    #1 check(slave_select_outputs_o, 8'h00);
    ssrvo_host_model_inst.cyc(16'h5FFF, 8'h00, 1'b0, 1'b1);
    #1 check(slave_select_outputs_o, 8'h00);
    check(ext_drv_en_o, 1'b0);
    ssrvo_host_model_inst.rel();
    $display("slave select done");
  endtask
  // bank latch feeds banked address, rom upper bits and bank decode
  task automatic t_bank();
    ssrvo_host_model_inst.strobe(1'b1, 8'h35);
    nclk(1);
    check(banked_upper_address_o, 4'h5);
    program_sel_i = 1'b1;
    ssrvo_host_model_inst.cyc(16'hC000, 8'h00, 1'b0, 1'b1);
    #1 check(system_rom_upper_address_o, 4'h5);
    nclk(1);
    program_sel_i = 1'b0;
    #1 check(system_rom_upper_address_o, 4'h3);
    ssrvo_host_model_inst.cyc(16'h3FFF, 8'h00, 1'b0, 1'b1);
    #1 check(bank_select_o, 8'h08);
    ssrvo_host_model_inst.cyc(16'h4000, 8'h00, 1'b0, 1'b1);
    #1 check(bank_select_o, 8'h00);
    ssrvo_host_model_inst.rel();
    $display("banking done");
  endtask
  // half-cycle ownership, refusals and both data drivers
  task automatic t_switch();
    ssrvo_host_model_inst.strobe(1'b0, 8'h0C);
    e_wait(1'b0);
    e_wait(1'b1);
    for (k = 0; k < 40 && host_e_phase_o === 1'b1; k++) nclk(1);
    check(k, 12);
    check(local_e_phase_o, 1'b1);
    check(local_q_phase_o, !host_q_phase_o);
    ssrvo_host_model_inst.cyc(16'h6010, 8'h5A, 1'b1, 1'b0);
    nclk(1);
    check(ram_ce_o, 1'b0);
    ssrvo_host_model_inst.rel();
    {local_valid_i, local_wr_i} = 2'b11;
    local_addr_i  = 13'h1234;
    nclk(1);
    check({ram_ce_o, ram_we_o, local_drv_en_o, host_drv_en_o}, 4'hE);
    check(ram_addr_o, 13'h1234);
    {local_valid_i, local_wr_i} = 2'b00;
    e_wait(1'b1);
    ssrvo_host_model_inst.cyc(16'h6010, 8'h5A, 1'b1, 1'b0);
    nclk(1);
    check({ram_ce_o, ram_we_o, local_drv_en_o, host_drv_en_o}, 4'hD);
    check(ram_addr_o, 13'h0010);
    ssrvo_host_model_inst.rel();
    $display("bus switch done");
  endtask
  // slave cpu held until loading is over
  task automatic t_run();
    check(slave_run_o, 1'b0);
    ssrvo_host_model_inst.loaded();
    check(slave_run_o, 1'b1);
    $display("slave run done");
  endtask
  // every channel once, then an out-of-range one is ignored
  task automatic t_route();
    for (int c = 0; c < 6; c++) begin
      route_idx_i  = 3'h7;
      route_chan_i = 3'(c);
      route_wr_i   = 1'b1;
      nclk(1);
      route_wr_i   = 1'b0;
      nclk(1);
      check(channel_enable_o[39:35], (c < 5) ? 5'h01 << c : 5'h10);
    end
    check(channel_enable_o[34:0], 35'h042108421);
    $display("crosspoint done");
  endtask
  // envelope value shows in its slot, hold in the second half
  task automatic t_env();
    {env_idx_i, env_data_i, env_wr_i} = {3'h2, 12'hABC, 1'b1};
    nclk(1);
    env_wr_i = 1'b0;
    for (k = 0; k < 900 && env_mux_sel_o !== 3'h2; k++) nclk(1);
    if (env_mux_sel_o !== 3'h2) give_up();
    nclk(2);
    check({env_dac_o, env_hold_o}, {12'hABC, 1'b0});
    nclk(60);
    check({env_mux_sel_o, env_hold_o}, {3'h2, 1'b1});
    $display("envelope done");
  endtask
  task automatic t_wr_timer(input logic [2:0] idx);
    {timer_idx_i, timer_data_i, timer_wr_i} = {idx, 16'h0003, 1'b1};
    nclk(1);
    timer_wr_i = 1'b0;
  endtask
  // wait for a fetch request of voice 0 and answer it
  task automatic fetch(input logic [15:0] w);
    for (k = 0; k < 100 && dma_req_o !== 4'h1; k++) nclk(1);
    if (dma_req_o !== 4'h1) give_up();
    {dma_data_i, dma_ack_i} = {w, 1'b1};
    nclk(1);
    dma_ack_i = 1'b0;
    dma_data_i = ~w;
    nclk(1);
    check(dma_req_o, 4'h0);
  endtask
  // timer ticks pace fetch and load; loads only under permit
  task automatic t_stream();
    t_wr_timer(3'h0);
    fetch(16'hA55A);
    fetch(16'h3CC3);
    check(dac_sample_o, 64'h0);
    dac_transfer_permit_i = 1'b1;
    for (k = 0; k < 100 && dma_req_o !== 4'h1; k++) nclk(1);
    if (dma_req_o !== 4'h1) give_up();
    check(dac_sample_o, 64'h3CC3);
    t_wr_timer(3'h4);
    for (k = 0; k < 100 && env_tick_o !== 1'b1; k++) nclk(1);
    check(env_tick_o, 1'b1);
    nclk(1);
    check(env_tick_o, 1'b0);
    $display("streaming done");
  endtask
  initial begin
    clock_i = 1'b0;
    nrst_i  = 1'b0;
    {program_sel_i, local_valid_i, local_wr_i, timer_wr_i, dma_ack_i} = '0;
    {dac_transfer_permit_i, env_wr_i, route_wr_i} = '0;
    {board_id_i, timer_idx_i, env_idx_i, route_idx_i, route_chan_i} = {3'h3, 12'h0};
    {local_addr_i, timer_data_i, dma_data_i, env_data_i} = '0;
    n_errors = 0;
    checks_done = 0;
    nclk(2);
    nrst_i = 1'b1;
    nclk(3);
    t_reset();
    t_select();
    t_bank();
    t_switch();
    t_run();
    t_route();
    t_env();
    t_stream();
    end_sim();
  end
endmodule
`default_nettype wire
